// *** logic/nst_nack_if.sv ***
// carrier between the register bank and the nack monitor
`timescale 1ns/1ps
interface nst_nack_if;
    logic       nack_event;
    logic       count_restart;
    logic       flag_clear;
    logic       short_nack_threshold;
    logic       excessive_nack_flag;

    modport monitor (
        input  nack_event,
        input  count_restart,
        input  flag_clear,
        input  short_nack_threshold,
        output excessive_nack_flag
    );
    modport control (
        output nack_event,
        output count_restart,
        output flag_clear,
        output short_nack_threshold,
        input  excessive_nack_flag
    );
endinterface

// *** logic/nst_nack_monitor.sv ***
// counts nacks to free buffer enquiries and raises the excessive nack flag
`timescale 1ns/1ps
`include "nst_setup_map.svh"
module nst_nack_monitor
    import nst_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    // register bank side
    nst_nack_if.monitor     nack
);

    nst_mon_state_type state_q;
    logic [7:0]        count_q;
    logic [7:0]        limit;
    logic              hit;

    // threshold follows the setup bit live; a change mid-run applies at once
    assign limit = nack.short_nack_threshold ? `NST_NACK_SHORT : `NST_NACK_LONG;
    assign hit   = nack.nack_event && (count_q + 8'h01 >= limit);

    // nack counter and flag sequencing; a new event beats a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_q <= NST_MON_IDLE;
            count_q <= 8'h00;
        end else begin
            case (state_q)
                NST_MON_IDLE: begin
                    count_q <= 8'h00;
                    if (hit) begin
                        state_q <= NST_MON_FLAGGED;
                    end else if (nack.nack_event) begin
                        state_q <= NST_MON_COUNT;
                        count_q <= 8'h01;
                    end
                end
                NST_MON_COUNT: begin
                    if (hit) begin
                        state_q <= NST_MON_FLAGGED;
                        count_q <= 8'h00;
                    end else if (nack.count_restart) begin
                        state_q <= NST_MON_IDLE;
                        count_q <= 8'h00;
                    end else if (nack.nack_event) begin
                        count_q <= count_q + 8'h01;
                    end
                end
                NST_MON_FLAGGED: begin
                    // sticky until cleared, and a fresh nack keeps it set
                    if (nack.flag_clear && !nack.nack_event) begin
                        state_q <= NST_MON_IDLE;
                    end
                end
                default: begin
                    state_q <= NST_MON_IDLE;
                    count_q <= 8'h00;
                end
            endcase
        end
    end

    assign nack.excessive_nack_flag = (state_q == NST_MON_FLAGGED);

endmodule // nst_nack_monitor

// *** logic/nst_pkg.sv ***
// types shared by the setup register block
package nst_pkg;

    // register selected at the shared address by the two subaddress bits
    typedef enum logic [1:0] {
        NST_SEL_TENTATIVE = 2'b00,
        NST_SEL_NODE      = 2'b01,
        NST_SEL_SETUP     = 2'b10,
        NST_SEL_NEXT      = 2'b11
    } nst_subsel_type;

    // state of the excessive nack monitor
    typedef enum logic [1:0] {
        NST_MON_IDLE    = 2'b00,
        NST_MON_COUNT   = 2'b01,
        NST_MON_FLAGGED = 2'b10
    } nst_mon_state_type;

endpackage

// *** logic/nst_setup_map.svh ***
// offsets, field positions, reset values and timing counts of the setup registers
`ifndef NST_SETUP_MAP_SVH
`define NST_SETUP_MAP_SVH

// register addresses on the parallel register port
`define NST_SUBEXT_OFFSET      3'h5
`define NST_CONFIG_OFFSET      3'h6
`define NST_SHARED_OFFSET      3'h7

// configuration and subaddress extension register fields
`define NST_CFG_SUBADDRESS_SELECT_LSB      0
`define NST_CFG_SUBADDRESS_SELECT_MSB      1
`define NST_SUBEXT_SETUP2_BIT  0

// first setup register fields
`define NST_S1_PULSE_BIT       7
`define NST_S1_FOURNACK_BIT    6
`define NST_S1_RESERVED_BIT    5
`define NST_S1_RXALL_BIT       4
`define NST_S1_PRESC_MSB       3
`define NST_S1_PRESC_LSB       1
`define NST_S1_SLOW_ARBITRATION_SELECT_BIT     0

// second setup register fields
`define NST_S2_FASTRD_BIT      7
`define NST_S2_RSVD_MSB        6
`define NST_S2_RSVD_LSB        4
`define NST_S2_EF_BIT          3

// reset values
`define NST_SETUP1_RESET       8'h06
`define NST_SETUP2_RESET       8'h00
`define NST_CONFIG_RESET       8'h00
`define NST_SUBEXT_RESET       8'h00
`define NST_ID_RESET           8'h00

// prescaler codes and divisors
`define NST_PRESC_FAST         3'h3
`define NST_PRESC_SLOW         3'h4
`define NST_DIV_FAST           8'h40
`define NST_DIV_SLOW           8'h80

// nack thresholds
`define NST_NACK_SHORT         8'h04
`define NST_NACK_LONG          8'h80

// timing: reference crystal, core clock, cycles per data bit
`define NST_CRYSTAL_MHZ        20
`define NST_CLK_MHZ            250
`define NST_BIT_CYCLES(div)    (((div) * `NST_CLK_MHZ) / `NST_CRYSTAL_MHZ)

`endif

// *** logic/nst_setup_regs.sv ***
// setup register bank of the token passing network controller
`timescale 1ns/1ps
`include "nst_setup_map.svh"

//
// Operation
// - setup-one bit 7: pulse driver push-pull when one, open-drain when zero (default).
// - excessive nack flag after short_nack_threshold if bit 6 set, else after 128.
// - setup-one bit 4 accepts every valid packet regardless of destination.
// - acknowledge only packets addressed to our own programmed node ID.
// - receive-all works with transmitter on or off; off gives listen-only.
// - setup-one bits 3..1 pick divisor: 011 gives 64 (default), 100 gives 128.
// - setup-one bit 0 halves the buffer arbitration clock, resets to zero.
// - setup-two bit 7 plus bus-timing pin both one enable fast reads.
// - setup-two bit 3 enables enhanced functions; zero keeps legacy behaviour.
// - setup-one sits at address 07 when subaddress bits hold one-zero.
module nst_setup_regs
    import nst_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    // parallel register port
    input  wire logic [2:0] addr_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o,
    // bus timing strap pin
    input  wire logic       bus_timing_pin_i,
    // controller core status
    input  wire logic [7:0] next_id_i,
    input  wire logic       nack_event_i,
    input  wire logic       nack_restart_i,
    input  wire logic       excessive_nack_flag_clear_i,
    output logic            excessive_nack_flag_o,
    // receive filter
    input  wire logic       pkt_valid_i,
    input  wire logic [7:0] pkt_dest_id_i,
    input  wire logic       tx_enable_i,
    output logic            pkt_accept_o,
    output logic            pkt_ack_o,
    output logic            token_pass_enable_o,
    // line pulse driver
    input  wire logic       pulse_active_i,
    output logic            line_pulse_output_o,
    output logic            line_pulse_oe_o,
    // configuration to the core
    output logic      [7:0] node_id_o,
    output logic      [7:0] rate_divisor_o,
    output logic            bit_tick_o,
    output logic            arb_enable_o,
    output logic            fast_read_active_o,
    output logic            receive_all_enable_o,
    output logic            enhanced_function_enable_o
);

    localparam int unsigned FAST_CYCLES = `NST_BIT_CYCLES(64);
    localparam int unsigned SLOW_CYCLES = `NST_BIT_CYCLES(128);

    // register state
    logic [7:0]     setup1_q;
    logic [7:0]     setup2_q;
    logic [7:0]     config_q;
    logic [7:0]     subext_q;
    logic [7:0]     tentative_id_q;
    logic [7:0]     node_id_q;
    logic [7:0]     rdata_q;
    nst_subsel_type subaddress_select;
    logic           setup2_select;
    logic           shared_wr;

    // pin synchroniser and derived state
    logic           bus_timing_meta_q;
    logic           bus_timing_pin_q;
    logic [10:0]    bit_count_q;
    logic           bit_tick_q;
    logic           arb_phase_q;
    logic           pkt_accept_q;
    logic           pkt_ack_q;
    logic           pulse_out_q;
    logic           pulse_oe_q;

    nst_nack_if     nack_bus ();

    // map prescaler code to divisor; unlisted codes fall back to the default rate
    function automatic logic [7:0] presc_divisor(input logic [2:0] code);
        case (code)
            `NST_PRESC_SLOW: presc_divisor = `NST_DIV_SLOW;
            default:         presc_divisor = `NST_DIV_FAST;
        endcase
    endfunction

    // cycles of clk_i per data bit for a prescaler code
    function automatic logic [10:0] presc_cycles(input logic [2:0] code);
        if (code == `NST_PRESC_SLOW) begin
            presc_cycles = 11'(SLOW_CYCLES);
        end else begin
            presc_cycles = 11'(FAST_CYCLES);
        end
    endfunction

    // shared address decode
    assign subaddress_select = nst_subsel_type'(config_q[`NST_CFG_SUBADDRESS_SELECT_MSB:`NST_CFG_SUBADDRESS_SELECT_LSB]);
    assign setup2_select     = subext_q[`NST_SUBEXT_SETUP2_BIT];
    assign shared_wr         = wr_i && (addr_i == `NST_SHARED_OFFSET);

    // configuration and subaddress extension registers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            config_q <= `NST_CONFIG_RESET;
            subext_q <= `NST_SUBEXT_RESET;
        end else if (wr_i) begin
            if (addr_i == `NST_CONFIG_OFFSET) begin
                config_q <= wdata_i;
            end
            if (addr_i == `NST_SUBEXT_OFFSET) begin
                subext_q <= wdata_i;
            end
        end
    end

    // registers behind the shared address, steered by the subaddress bits
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            setup1_q       <= `NST_SETUP1_RESET;
            setup2_q       <= `NST_SETUP2_RESET;
            tentative_id_q <= `NST_ID_RESET;
            node_id_q      <= `NST_ID_RESET;
        end else if (shared_wr) begin
            case (subaddress_select)
                NST_SEL_TENTATIVE: tentative_id_q <= wdata_i;
                NST_SEL_NODE:      node_id_q      <= wdata_i;
                NST_SEL_SETUP: begin
                    if (setup2_select) begin
                        // reserved bits 6..4 are held at zero whatever is written
                        setup2_q <= wdata_i & 8'h8F;
                    end else begin
                        // reserved bit kept clear even if software slips
                        setup1_q <= wdata_i & 8'hDF;
                    end
                end
                default: ; // next ID is read only
            endcase
        end
    end

    // read data from a flop, valid the cycle after rd_i; unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_q <= 8'h00;
        end else if (rd_i) begin
            if (addr_i == `NST_SHARED_OFFSET) begin
                case (subaddress_select)
                    NST_SEL_TENTATIVE: rdata_q <= tentative_id_q;
                    NST_SEL_NODE:      rdata_q <= node_id_q;
                    NST_SEL_SETUP:     rdata_q <= setup2_select ? setup2_q : setup1_q;
                    NST_SEL_NEXT:      rdata_q <= next_id_i;
                    default:           rdata_q <= 8'h00;
                endcase
            end else if (addr_i == `NST_CONFIG_OFFSET) begin
                rdata_q <= config_q;
            end else if (addr_i == `NST_SUBEXT_OFFSET) begin
                rdata_q <= subext_q;
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end

    // two-flop synchroniser on the asynchronous strap pin
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            bus_timing_meta_q <= 1'b0;
            bus_timing_pin_q  <= 1'b0;
        end else begin
            bus_timing_meta_q <= bus_timing_pin_i;
            bus_timing_pin_q  <= bus_timing_meta_q;
        end
    end

    // data-rate tick: one pulse per bit time at the selected divisor
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            bit_count_q <= 11'h000;
            bit_tick_q  <= 1'b0;
        end else if (bit_count_q >= presc_cycles(setup1_q[`NST_S1_PRESC_MSB:`NST_S1_PRESC_LSB]) - 11'h001) begin
            bit_count_q <= 11'h000;
            bit_tick_q  <= 1'b1;
        end else begin
            bit_count_q <= bit_count_q + 11'h001;
            bit_tick_q  <= 1'b0;
        end
    end

    // arbitration enable: every cycle, or every other cycle when slowed
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            arb_phase_q <= 1'b0;
        end else if (setup1_q[`NST_S1_SLOW_ARBITRATION_SELECT_BIT]) begin
            arb_phase_q <= ~arb_phase_q;
        end else begin
            arb_phase_q <= 1'b1;
        end
    end

    // receive filter; accept does not depend on the transmitter, ack does
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pkt_accept_q <= 1'b0;
            pkt_ack_q    <= 1'b0;
        end else begin
            pkt_accept_q <= pkt_valid_i && (setup1_q[`NST_S1_RXALL_BIT]
                            || pkt_dest_id_i == node_id_q);
            pkt_ack_q    <= pkt_valid_i && tx_enable_i
                            && pkt_dest_id_i == node_id_q;
        end
    end

    // pulse driver: open drain only pulls low, push-pull drives both levels
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pulse_out_q <= 1'b0;
            pulse_oe_q  <= 1'b0;
        end else if (setup1_q[`NST_S1_PULSE_BIT]) begin
            pulse_out_q <= ~pulse_active_i;
            pulse_oe_q  <= 1'b1;
        end else begin
            pulse_out_q <= 1'b0;
            pulse_oe_q  <= pulse_active_i;
        end
    end

    // nack monitor hookup
    assign nack_bus.nack_event           = nack_event_i;
    assign nack_bus.count_restart        = nack_restart_i;
    assign nack_bus.flag_clear           = excessive_nack_flag_clear_i;
    assign nack_bus.short_nack_threshold = setup1_q[`NST_S1_FOURNACK_BIT];

    nst_nack_monitor u_nack_monitor (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .nack    (nack_bus)
    );

    // outputs
    assign rdata_o                    = rdata_q;
    assign excessive_nack_flag_o      = nack_bus.excessive_nack_flag;
    assign pkt_accept_o               = pkt_accept_q;
    assign pkt_ack_o                  = pkt_ack_q;
    assign token_pass_enable_o        = tx_enable_i;
    assign line_pulse_output_o        = pulse_out_q;
    assign line_pulse_oe_o            = pulse_oe_q;
    assign node_id_o                  = node_id_q;
    assign rate_divisor_o             = presc_divisor(setup1_q[`NST_S1_PRESC_MSB:`NST_S1_PRESC_LSB]);
    assign bit_tick_o                 = bit_tick_q;
    assign arb_enable_o               = arb_phase_q;
    assign fast_read_active_o         = setup2_q[`NST_S2_FASTRD_BIT] && bus_timing_pin_q;
    assign receive_all_enable_o       = setup1_q[`NST_S1_RXALL_BIT];
    // legacy timing whenever this is low; host must raise it above 5Mbps
    assign enhanced_function_enable_o = setup2_q[`NST_S2_EF_BIT];

endmodule // nst_setup_regs

// *** test/nst_host_model.sv ***
// host microcontroller model driving the parallel register port
`timescale 1ns/1ps
`include "nst_setup_map.svh"
module nst_host_model (
    // clock
    input  wire logic       clk_i,
    // register port towards the device
    output logic      [2:0] addr_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic      [7:0] wdata_o,
    input  wire logic [7:0] rdata_i
);
    // bus idle until a cycle is asked for
    initial begin
        addr_o  = 3'h0;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        wdata_o = 8'h00;
    end

    // one write, held for its single taking edge
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        wdata_o <= ~d; // stale data must not look valid
    endtask

    // one read; data lands at the taking edge
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        #1 d = rdata_i;
    endtask

    // point the shared address at one register; ext picks the second setup
    task automatic sel(input logic [1:0] sub, input logic ext);
        wr(`NST_SUBEXT_OFFSET, {7'h00, ext});
        wr(`NST_CONFIG_OFFSET, {6'h00, sub});
    endtask

    // software keeps reserved setup bits clear
    task automatic put_setup(input logic ext, input logic [7:0] d);
        sel(2'b10, ext);
        wr(`NST_SHARED_OFFSET, ext ? (d & 8'h8F) : (d & 8'hDF));
    endtask
endmodule // nst_host_model

// *** test/nst_setup_regs_asserts.sv ***
// concurrent checks on the setup register block ports
`timescale 1ns/1ps
module nst_setup_regs_asserts (
    // clock, reset and register port
    input wire logic       clk_i,
    input wire logic       reset_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       bus_timing_pin_i,
    // nack monitor
    input wire logic       nack_event_i,
    input wire logic       excessive_nack_flag_clear_i,
    input wire logic       excessive_nack_flag_o,
    // receive filter
    input wire logic       pkt_valid_i,
    input wire logic [7:0] pkt_dest_id_i,
    input wire logic       tx_enable_i,
    input wire logic       pkt_accept_o,
    input wire logic       pkt_ack_o,
    input wire logic       token_pass_enable_o,
    // pulse pin and core settings
    input wire logic       line_pulse_output_o,
    input wire logic       line_pulse_oe_o,
    input wire logic [7:0] node_id_o,
    input wire logic [7:0] rate_divisor_o,
    input wire logic       bit_tick_o,
    input wire logic       arb_enable_o,
    input wire logic       fast_read_active_o,
    input wire logic       receive_all_enable_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // register port and pin relations
    a_read_holds: assert property (!rd_i |=> $stable(rdata_o))
        else $error("read data moved without a read");
    a_open_drain: assert property (line_pulse_output_o |-> line_pulse_oe_o)
        else $error("pulse pin driven high while released");
    // synchroniser depth gives two cycles of pin history; the check also accepts three
    a_fast_read_pin: assert property (fast_read_active_o |->
        $past(bus_timing_pin_i, 2) || $past(bus_timing_pin_i, 3))
        else $error("fast read without the timing pin");
    a_divisor_legal: assert property (rate_divisor_o inside {8'h40, 8'h80})
        else $error("rate divisor outside the two codes");
    a_tick_pulse: assert property (bit_tick_o |=> !bit_tick_o [*8])
        else $error("bit tick repeats too soon");
    a_arb_resumes: assert property (!arb_enable_o |-> ##[1:2] arb_enable_o)
        else $error("arbitration clock stalled");

    // receive filter relations
    a_accept_own: assert property (pkt_valid_i &&
        (pkt_dest_id_i == node_id_o || receive_all_enable_o) |=> pkt_accept_o)
        else $error("packet not accepted");
    a_accept_cause: assert property (pkt_accept_o |-> $past(pkt_valid_i))
        else $error("accept without a packet");
    a_ack_own_id: assert property (pkt_ack_o |->
        $past(pkt_valid_i) && $past(tx_enable_i) && $past(pkt_dest_id_i) == $past(node_id_o))
        else $error("ack for a foreign packet");
    a_token_copy: assert property (token_pass_enable_o == tx_enable_i)
        else $error("token passing while transmitter off");

    // nack flag relations
    a_flag_cause: assert property ($rose(excessive_nack_flag_o) |-> $past(nack_event_i))
        else $error("nack flag rose without a nack");
    a_flag_sticky: assert property (excessive_nack_flag_o && !excessive_nack_flag_clear_i
        |=> excessive_nack_flag_o)
        else $error("nack flag dropped without clear");
endmodule // nst_setup_regs_asserts

bind nst_setup_regs nst_setup_regs_asserts nst_setup_regs_asserts_inst (
    .clk_i, .reset_i, .rd_i, .rdata_o, .bus_timing_pin_i, .nack_event_i,
    .excessive_nack_flag_clear_i, .excessive_nack_flag_o, .pkt_valid_i, .pkt_dest_id_i,
    .tx_enable_i, .pkt_accept_o, .pkt_ack_o, .token_pass_enable_o,
    .line_pulse_output_o, .line_pulse_oe_o, .node_id_o, .rate_divisor_o,
    .bit_tick_o, .arb_enable_o, .fast_read_active_o, .receive_all_enable_o
);

// *** test/tb_nst_setup_regs.sv ***
// self-checking bench for the setup register block
`timescale 1ns/1ps
module tb_nst_setup_regs;
    logic       clk_i, reset_i, wr_i, rd_i, pin, nev, nrs, ncl, flag, pv, tx, acc, ack, tok;
    logic       pact, pout, poe, tick, arb, fast, rxall, ef;
    logic [2:0] addr_i;
    logic [7:0] wdata_i, rdata_o, next_id, dest, node, div;
    int         mismatches, check_count;

    nst_host_model nst_host_model_inst (.clk_i, .addr_o(addr_i), .wr_o(wr_i), .rd_o(rd_i),
        .wdata_o(wdata_i), .rdata_i(rdata_o));

    nst_setup_regs nst_setup_regs_inst (.clk_i, .reset_i, .addr_i, .wr_i, .rd_i, .wdata_i,
        .rdata_o, .bus_timing_pin_i(pin), .next_id_i(next_id), .nack_event_i(nev),
        .nack_restart_i(nrs), .excessive_nack_flag_clear_i(ncl), .excessive_nack_flag_o(flag),
        .pkt_valid_i(pv), .pkt_dest_id_i(dest), .tx_enable_i(tx), .pkt_accept_o(acc),
        .pkt_ack_o(ack), .token_pass_enable_o(tok), .pulse_active_i(pact),
        .line_pulse_output_o(pout), .line_pulse_oe_o(poe), .node_id_o(node),
        .rate_divisor_o(div), .bit_tick_o(tick), .arb_enable_o(arb),
        .fast_read_active_o(fast), .receive_all_enable_o(rxall),
        .enhanced_function_enable_o(ef));

    // 250 MHz clock
    always #2 clk_i = ~clk_i;

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // shorthands onto the host model
    task automatic put(input logic e, input logic [7:0] d);
        nst_host_model_inst.put_setup(e, d);
    endtask
    task automatic rd7(input logic [1:0] sub, input logic e, output logic [7:0] v);
        nst_host_model_inst.sel(sub, e);
        nst_host_model_inst.rd(3'h7, v);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // wait for the next bit tick, bounded; n is the cycles taken
    task automatic wait_tick(output int n);
        n = 0;
        do begin
            step(1);
            n++;
        end while (!tick && n < 2000);
        if (!tick) begin
            mismatches++;
            $display("unexpected bit tick: expected pulse, seen none");
            final_report();
        end
    endtask

    task automatic t_reset();
        logic [7:0] v;
        int         n;
        rd7(2'b10, 1'b0, v);
        chk("setup one", 8'h06, v);
        rd7(2'b10, 1'b1, v);
        chk("setup two", 8'h00, v);
        chk("divisor", 8'h40, div);
        chk("pulse enable", 8'h00, poe);
        chk("features", 8'h00, {rxall, ef, flag});
        nst_host_model_inst.rd(3'h0, v);
        chk("unmapped", 8'h00, v);
        wait_tick(n);
        wait_tick(n);
        chk("tick period hi", 8'h03, 8'(n >> 8));
        chk("tick period lo", 8'h20, 8'(n));
        $display("test reset values done");
    endtask

    task automatic t_setup1();
        logic [7:0] v;
        logic       a;
        int         n;
        put(1'b0, 8'hD9);
        nst_host_model_inst.rd(3'h7, v);
        chk("setup one", 8'hD9, v);
        chk("divisor", 8'h80, div);
        chk("receive all", 8'h01, rxall);
        a = arb;
        step(1);
        chk("arb toggle", {7'h00, ~a}, arb);
        wait_tick(n);
        wait_tick(n);
        chk("slow tick hi", 8'h06, 8'(n >> 8));
        chk("slow tick lo", 8'h40, 8'(n));
        nst_host_model_inst.wr(3'h7, 8'h26); // reserved bit set on purpose
        nst_host_model_inst.rd(3'h7, v);
        chk("reserved bit", 8'h06, v);
        chk("divisor", 8'h40, div);
        $display("test setup one done");
    endtask

    task automatic t_pulse();
        @(posedge clk_i) pact <= 1'b1;
        step(2);
        chk("open drain", 8'h01, {pout, poe});
        @(posedge clk_i) pact <= 1'b0;
        step(2);
        chk("open drain idle", 8'h00, {pout, poe});
        put(1'b0, 8'h86);
        step(2);
        chk("push pull idle", 8'h03, {pout, poe});
        @(posedge clk_i) pact <= 1'b1;
        step(2);
        chk("push pull", 8'h01, {pout, poe});
        put(1'b0, 8'h06);
        $display("test pulse driver done");
    endtask

    // one packet and the filter verdict a cycle later
    task automatic pkt(input logic [7:0] id, input logic t, input logic [1:0] exp);
        @(posedge clk_i);
        pv   <= 1'b1;
        dest <= id;
        tx   <= t;
        @(posedge clk_i);
        pv   <= 1'b0;
        dest <= ~id;
        #1;
        chk("accept ack", {6'h00, exp}, {acc, ack});
        chk("token pass", {7'h00, t}, tok);
    endtask

    task automatic t_filter();
        logic [7:0] v;
        nst_host_model_inst.sel(2'b01, 1'b0);
        nst_host_model_inst.wr(3'h7, 8'h2A);
        step(1);
        chk("node id", 8'h2A, node);
        rd7(2'b11, 1'b0, v);
        chk("next id", 8'h5C, v);
        put(1'b0, 8'h16);
        pkt(8'h33, 1'b1, 2'b10);
        pkt(8'h2A, 1'b1, 2'b11);
        pkt(8'h2A, 1'b0, 2'b10);
        put(1'b0, 8'h06);
        pkt(8'h33, 1'b1, 2'b00);
        $display("test receive filter done");
    endtask

    task automatic nacks(input int n);
        @(posedge clk_i) nev <= 1'b1;
        repeat (n - 1) @(posedge clk_i);
        @(posedge clk_i) nev <= 1'b0;
        #1;
    endtask
    task automatic pulse_clear();
        @(posedge clk_i) ncl <= 1'b1;
        @(posedge clk_i) ncl <= 1'b0;
        @(posedge clk_i) nrs <= 1'b1;
        @(posedge clk_i) nrs <= 1'b0;
        #1;
    endtask

    task automatic t_nack();
        nacks(127);
        chk("flag at 127", 8'h00, flag);
        nacks(1);
        chk("flag at 128", 8'h01, flag);
        pulse_clear();
        chk("flag cleared", 8'h00, flag);
        put(1'b0, 8'h46);
        nacks(3);
        chk("flag at 3", 8'h00, flag);
        nacks(1);
        chk("flag at 4", 8'h01, flag);
        pulse_clear();
        put(1'b0, 8'h06);
        $display("test nack threshold done");
    endtask

    task automatic t_setup2();
        logic [7:0] v;
        nst_host_model_inst.sel(2'b10, 1'b1);
        nst_host_model_inst.wr(3'h7, 8'hF8); // reserved bits set on purpose
        nst_host_model_inst.rd(3'h7, v);
        chk("setup two", 8'h88, v);
        chk("enhanced", 8'h01, ef);
        @(posedge clk_i) pin <= 1'b1;
        step(4);
        chk("fast read", 8'h01, fast);
        @(posedge clk_i) pin <= 1'b0;
        step(4);
        chk("fast read no pin", 8'h00, fast);
        put(1'b1, 8'h08);
        @(posedge clk_i) pin <= 1'b1;
        step(4);
        chk("fast read no bit", 8'h00, fast);
        $display("test setup two done");
    endtask

    // hang guard
    initial begin
        repeat (100000) @(posedge clk_i);
        mismatches++;
        $display("unexpected run length: expected end, seen none");
        final_report();
    end

    // reset, then every scenario in turn
    initial begin
        {clk_i, pin, nev, nrs, ncl, pv, tx, pact} = '0;
        reset_i = 1'b1;
        dest    = 8'h00;
        next_id = 8'h5C;
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        t_reset();
        t_setup1();
        t_pulse();
        t_filter();
        t_nack();
        t_setup2();
        final_report();
    end
endmodule // tb_nst_setup_regs
